// file: verilog/simoc_regs.sv
// control register bank: interrupt mask, rail 1 target and configuration
// assumes ahb-lite single master, word transfers, synchronous events
`timescale 1ns/1ps
module simoc_regs
  import simoc_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // interrupt events (bit order of the mask register)
  input wire logic [7:0] irq_event,
  output logic irq,
  // rail 1 controls
  output logic [12:0] rail1_target_mv,
  output logic [1:0] peak_current_limit_select,
  output logic active_discharge_enable,
  output logic rail1_force_on,
  output logic [5:0] rail1_powerup_delay_ms,
  output logic [5:0] rail1_powerdown_delay_ms,
  output logic rail1_in_sequencer
);
  import simoc_pkg::*;

  simoc_irq_if irq_bus ();

  logic [7:0] int_mask_q;
  logic [7:0] rail1_target_q;
  logic [7:0] rail1_cfg_q;
  logic [7:0] irq_enable_q;
  logic [7:0] irq_clear_q;
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [31:0] hrdata_q;
  logic [7:0] rd_idx;
  logic addr_ok;
  logic [7:0] wbyte;
  logic [4:0] en_field;
  logic [12:0] target_d;
  logic [5:0] up_d;

  // address phase decode: word transfers only, index is haddr[9:2]
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ)
    && (hsize == HSIZE_WORD) && (haddr[1:0] == 2'b00)
    && (haddr[31:10] == 22'h0);
  assign rd_idx = haddr[9:2];
  assign wbyte = hwdata[7:0];

  // the slave never stalls and never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // capture write address, data follows in the next cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q <= rd_idx;
    end
  end

  // read data registered at the address phase; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (srst)
      hrdata_q <= 32'h0;
    else if (ce && addr_ok && !hwrite)
    begin
      case (rd_idx)
        IDX_INT_MASK: hrdata_q <= {24'h0, int_mask_q};
        IDX_RAIL1_TARGET: hrdata_q <= {24'h0, rail1_target_q};
        IDX_RAIL1_CFG: hrdata_q <= {24'h0, rail1_cfg_q};
        IDX_IRQ_STATUS: hrdata_q <= {24'h0, irq_bus.status};
        IDX_IRQ_ENABLE: hrdata_q <= {24'h0, irq_enable_q};
        default: hrdata_q <= 32'h0;
      endcase
    end
  end

  // mask register, reserved bit 6 held at zero
  always_ff @(posedge clk)
  begin
    if (srst)
      int_mask_q <= RST_INT_MASK;
    else if (ce && wr_pend_q && wr_idx_q == IDX_INT_MASK)
      int_mask_q <= wbyte & INT_BITS;
  end

  // rail 1 target code
  always_ff @(posedge clk)
  begin
    if (srst)
      rail1_target_q <= RST_RAIL1_TARGET;
    else if (ce && wr_pend_q && wr_idx_q == IDX_RAIL1_TARGET)
      rail1_target_q <= wbyte;
  end

  // rail 1 limit, discharge and enable control
  always_ff @(posedge clk)
  begin
    if (srst)
      rail1_cfg_q <= RST_RAIL1_CFG;
    else if (ce && wr_pend_q && wr_idx_q == IDX_RAIL1_CFG)
      rail1_cfg_q <= wbyte;
  end

  // interrupt enable register
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_enable_q <= RST_IRQ_ENABLE;
    else if (ce && wr_pend_q && wr_idx_q == IDX_IRQ_ENABLE)
      irq_enable_q <= wbyte & INT_BITS;
  end

  // write-one-to-clear strobe, lasts one cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_clear_q <= 8'h00;
    else if (ce)
      irq_clear_q <= (wr_pend_q && wr_idx_q == IDX_IRQ_CLEAR) ?
        (wbyte & INT_BITS) : 8'h00;
  end

  assign irq_bus.flags = irq_event;
  assign irq_bus.mask = int_mask_q;
  assign irq_bus.enable = irq_enable_q;
  assign irq_bus.clear = irq_clear_q;
  assign irq = irq_bus.irq;

  simoc_irq_unit u_irq (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .irq_io(irq_bus)
  );

  // decoded rail 1 settings
  assign en_field = rail1_cfg_q[4:0];
  always_comb
  begin
    target_d = MV_BASE + MV_STEP * {6'h0, rail1_target_q[6:0]};
    if (rail1_target_q[TGT_OFFSET_BIT])
      target_d = target_d + MV_OFFSET;
    up_d = DLY_STEP_MS * {4'h0, en_field[EN_UPDLY_LSB +: 2]};
  end

  // target in millivolts, registered so the rail never sees a decode glitch
  always_ff @(posedge clk)
  begin
    if (srst)
      rail1_target_mv <= 13'h0;
    else if (ce)
      rail1_target_mv <= target_d;
  end

  chk_target_mv : assert property (@(posedge clk)
    disable iff (srst)
    ce |=> rail1_target_mv == 13'd800 + 13'd25 * $past(rail1_target_q[6:0])
      + ($past(rail1_target_q[7]) ? 13'd1200 : 13'd0))
    else $error("target voltage wrong");

  // current limit code goes to the switch-node driver through one register
  always_ff @(posedge clk)
  begin
    if (srst)
      peak_current_limit_select <= 2'h0;
    else if (ce)
      peak_current_limit_select <= rail1_cfg_q[CFG_PEAK_CURRENT_LIMIT_SELECT_LSB +: 2];
  end

  chk_peak_current_limit_select : assert property (@(posedge clk) disable iff (srst)
    ce |=> peak_current_limit_select == $past(rail1_cfg_q[7:6]))
    else $error("current limit select wrong");

  // discharge resistor switch
  always_ff @(posedge clk)
  begin
    if (srst)
      active_discharge_enable <= 1'b0;
    else if (ce)
      active_discharge_enable <= rail1_cfg_q[CFG_ADE_BIT];
  end

  chk_discharge : assert property (@(posedge clk) disable iff (srst)
    ce |=> active_discharge_enable == $past(rail1_cfg_q[5]))
    else $error("discharge control wrong");

  // forced enable, which overrides the sequencer downstream
  always_ff @(posedge clk)
  begin
    if (srst)
      rail1_force_on <= 1'b0;
    else if (ce)
      rail1_force_on <= en_field[EN_FORCE_BIT];
  end

  chk_force_on : assert property (@(posedge clk) disable iff (srst)
    ce |=> rail1_force_on == $past(rail1_cfg_q[0]))
    else $error("force on wrong");

  // power-up delay in ms
  always_ff @(posedge clk)
  begin
    if (srst)
      rail1_powerup_delay_ms <= 6'h0;
    else if (ce)
      rail1_powerup_delay_ms <= up_d;
  end

  chk_up_delay : assert property (@(posedge clk) disable iff (srst)
    ce |=> rail1_powerup_delay_ms == 6'd10 * $past(rail1_cfg_q[4:3]))
    else $error("power-up delay wrong");

  // power-down delay: with bit 2 set the two delays share one fixed 30 ms total window, otherwise zero
  always_ff @(posedge clk)
  begin
    if (srst)
      rail1_powerdown_delay_ms <= 6'h0;
    else if (ce)
      rail1_powerdown_delay_ms <= en_field[EN_DNDLY_BIT] ?
        (DLY_TOTAL_MS - up_d) : 6'h0;
  end

  chk_down_delay : assert property (@(posedge clk)
    disable iff (srst)
    ce |=> rail1_powerdown_delay_ms == ($past(rail1_cfg_q[2]) ?
      6'd30 - 6'd10 * $past(rail1_cfg_q[4:3]) : 6'd0))
    else $error("power-down delay wrong");

  // sequencer membership
  always_ff @(posedge clk)
  begin
    if (srst)
      rail1_in_sequencer <= 1'b0;
    else if (ce)
      rail1_in_sequencer <= en_field[EN_SEQ_BIT];
  end

  chk_sequencer : assert property (@(posedge clk) disable iff (srst)
    ce |=> rail1_in_sequencer == $past(rail1_cfg_q[1]))
    else $error("sequencer membership wrong");

  // register file checks: stores, read-back, reset and reserved bits
  chk_mask_write : assert property (@(posedge clk)
    disable iff (srst)
    ce && wr_pend_q && wr_idx_q == IDX_INT_MASK
    |=> int_mask_q == ($past(wbyte) & INT_BITS))
    else $error("mask write not stored");
  chk_target_write : assert property (@(posedge clk)
    disable iff (srst)
    ce && wr_pend_q && wr_idx_q == IDX_RAIL1_TARGET
    |=> rail1_target_q == $past(wbyte))
    else $error("target write not stored");
  chk_cfg_write : assert property (@(posedge clk)
    disable iff (srst)
    ce && wr_pend_q && wr_idx_q == IDX_RAIL1_CFG
    |=> rail1_cfg_q == $past(wbyte))
    else $error("config write not stored");
  chk_mask_readback : assert property (@(posedge clk)
    disable iff (srst)
    ce && addr_ok && !hwrite && rd_idx == IDX_INT_MASK
    |=> hrdata == {24'h0, $past(int_mask_q)})
    else $error("mask read data wrong");
  chk_target_reset : assert property (@(posedge clk)
    srst |=> rail1_target_q == 8'h10)
    else $error("target reset value wrong");
  chk_mask_reset : assert property (@(posedge clk)
    srst |=> int_mask_q == 8'h00)
    else $error("mask reset value wrong");
  chk_mask_reserved : assert property (@(posedge clk)
    disable iff (srst)
    (int_mask_q & 8'h40) == 8'h00)
    else $error("reserved mask bit set");
endmodule : simoc_regs

// file: verilog/simoc_pkg.sv
// package for the regulator control register bank
// assumes a single clock domain and an ahb-lite register bus
package simoc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_INT_MASK = 8'h11;
  localparam logic [7:0] IDX_RAIL1_TARGET = 8'h29;
  localparam logic [7:0] IDX_RAIL1_CFG = 8'h2a;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h41;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h42;
  // reset values
  localparam logic [7:0] RST_INT_MASK = 8'h00;
  localparam logic [7:0] RST_RAIL1_TARGET = 8'h10;
  localparam logic [7:0] RST_RAIL1_CFG = 8'hcf;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'hff;
  // implemented bits of the mask / flag layout (bit 6 reserved)
  localparam logic [7:0] INT_BITS = 8'hbf;
  // field positions
  localparam int TGT_OFFSET_BIT = 7;
  localparam int CFG_ADE_BIT = 5;
  localparam int CFG_PEAK_CURRENT_LIMIT_SELECT_LSB = 6;
  localparam int EN_FORCE_BIT = 0;
  localparam int EN_UPDLY_LSB = 3;
  localparam int EN_DNDLY_BIT = 2;
  localparam int EN_SEQ_BIT = 1;
  // voltage arithmetic in millivolts
  localparam logic [12:0] MV_BASE = 13'd800;
  localparam logic [12:0] MV_STEP = 13'd25;
  localparam logic [12:0] MV_OFFSET = 13'd1200;
  // delays in ms
  localparam logic [5:0] DLY_STEP_MS = 6'd10;
  localparam logic [5:0] DLY_TOTAL_MS = 6'd30;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage : simoc_pkg

// file: verilog/simoc_irq_if.sv
// interface between the register bank and its interrupt unit
// assumes one clock, used inside the design only
`timescale 1ns/1ps
interface simoc_irq_if;
  logic [7:0] flags;
  logic [7:0] mask;
  logic [7:0] enable;
  logic [7:0] clear;
  logic [7:0] status;
  logic irq;
  modport bank (output flags, mask, enable, clear, input status, irq);
  modport unit (input flags, mask, enable, clear, output status, irq);
endinterface : simoc_irq_if

// file: verilog/simoc_irq_unit.sv
// sticky interrupt flags and masked request output
// assumes event inputs are synchronous one-cycle or level pulses
`timescale 1ns/1ps
module simoc_irq_unit
  import simoc_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // bank side
  simoc_irq_if.unit irq_io
);
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic irq_q;

  // one sticky bit per event, set beats clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      always_comb
      begin
        if (irq_io.flags[gi] && INT_BITS[gi])
          status_d[gi] = 1'b1;
        else if (irq_io.clear[gi])
          status_d[gi] = 1'b0;
        else
          status_d[gi] = status_q[gi];
      end
    end
  endgenerate

  // flags latch even when masked
  always_ff @(posedge clk)
  begin
    if (srst)
      status_q <= 8'h00;
    else if (ce)
      status_q <= status_d;
  end

  // request follows unmasked and enabled flags, registered
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_q <= 1'b0;
    else if (ce)
      irq_q <= |(status_q & ~irq_io.mask & irq_io.enable);
  end

  assign irq_io.status = status_q;
  assign irq_io.irq = irq_q;

  chk_masked_no_irq : assert property (@(posedge clk)
    disable iff (srst)
    ce && ((status_q & ~irq_io.mask & irq_io.enable) == 8'h00)
    |=> !irq_q)
    else $error("request raised with no unmasked flag");
  chk_unmasked_irq : assert property (@(posedge clk)
    disable iff (srst)
    ce && ((status_q & ~irq_io.mask & irq_io.enable) != 8'h00)
    |=> irq_q)
    else $error("unmasked flag did not raise request");
  chk_set_wins : assert property (@(posedge clk) disable iff (srst)
    ce && irq_io.flags[0] |=> status_q[0])
    else $error("event lost against clear");
endmodule : simoc_irq_unit

// file: bench/simoc_host.sv
// host model: ahb-lite master doing single word transfers
// assumes one slave whose hreadyout comes back as hready
`timescale 1ns/1ps
module simoc_host
  import simoc_pkg::*;
(
  // clocking
  input wire logic clk,
  // bus
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  logic [31:0] rdata;
  event rd_ev;
  // idle bus at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
  end
  // bounded wait; a stuck bus ends the run
  task automatic hold;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1)
      simoc_regs_tb_top.hang();
  endtask : hold
  // address phase, then data phase; released data toggles, never holds
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hold();
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    hold();
    rdata = hrdata;
    if (!w)
      ->rd_ev;
  endtask : xfer
endmodule : simoc_host

// file: bench/simoc_regs_tb_top.sv
// testbench for the regulator control register bank
// assumes the host model drives the bus; events driven here
`timescale 1ns/1ps
module simoc_regs_tb_top;
  import simoc_pkg::*;
  logic clk, srst, ce, hsel, hwrite, hready, irq, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, peak_current_limit_select;
  logic [2:0] hsize;
  logic [7:0] irq_event, v;
  logic [12:0] rail1_target_mv;
  logic active_discharge_enable, rail1_force_on, rail1_in_sequencer;
  logic [5:0] rail1_powerup_delay_ms, rail1_powerdown_delay_ms;
  int fails, checks_done, seed, i, u;
  logic [31:0] exp_q[$];
  simoc_regs dut_u (
    .clk, .srst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .irq_event, .irq,
    .rail1_target_mv, .peak_current_limit_select,
    .active_discharge_enable, .rail1_force_on, .rail1_in_sequencer,
    .rail1_powerup_delay_ms, .rail1_powerdown_delay_ms
  );
  simoc_host host_u (
    .clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata
  );
  // 125 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_sim;
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic hang;
    fails++;
    end_sim();
  endtask : hang
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] x, input logic [31:0] d);
    host_u.xfer(1'b1, {22'h0, x, 2'b00}, d);
  endtask : wr
  // note the expectation before the read goes out
  task automatic rd(input logic [7:0] x, input logic [31:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'b0, {22'h0, x, 2'b00}, 32'h0);
  endtask : rd
  // decoded outputs and irq lag by a few edges
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic pulse(input int n);
    @(posedge clk);
    irq_event <= 8'h1 << n;
    @(posedge clk);
    irq_event <= 8'h0;
    settle();
  endtask : pulse
  // read monitor: each finished read takes the oldest note
  initial
    forever
    begin
      @(host_u.rd_ev);
      chk("hrdata", exp_q.pop_front(), host_u.rdata);
      chk("hresp", 32'h0, 32'(hresp));
    end
  // main sequence
  initial
  begin
    seed = 32'hbc746fb7;
    fails = 0;
    checks_done = 0;
    srst = 1'b1;
    ce = 1'b1;
    irq_event = 8'h0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(IDX_INT_MASK, 32'h0);
    rd(IDX_RAIL1_TARGET, 32'h10);
    rd(8'h00, 32'h0);
    chk("target_mv", 32'd1200, 32'(rail1_target_mv));
    for (i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      wr(IDX_INT_MASK, {24'h0, v});
      rd(IDX_INT_MASK, {24'h0, v & INT_BITS});
    end
    for (i = 0; i < 6; i++)
    begin
      v = i < 2 ? {8{i[0]}} : 8'($random(seed));
      wr(IDX_RAIL1_TARGET, {24'h0, v});
      rd(IDX_RAIL1_TARGET, {24'h0, v});
      settle();
      u = 800 + 25 * v[6:0] + (v[7] ? 1200 : 0);
      chk("target_mv", 32'(u), 32'(rail1_target_mv));
    end
    // frozen clock enable drops a write; a mid-run reset restores defaults
    @(posedge clk);
    ce <= 1'b0;
    wr(IDX_RAIL1_TARGET, 32'h55);
    ce <= 1'b1;
    rd(IDX_RAIL1_TARGET, {24'h0, v});
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(IDX_INT_MASK, 32'h0);
    rd(IDX_RAIL1_TARGET, 32'h10);
    rd(IDX_RAIL1_CFG, {24'h0, RST_RAIL1_CFG});
    chk("target_mv", 32'd1200, 32'(rail1_target_mv));
    chk("ade", 32'h0, 32'(active_discharge_enable));
    chk("up", 32'd10, 32'(rail1_powerup_delay_ms));
    chk("down", 32'd20, 32'(rail1_powerdown_delay_ms));
    chk("seq", 32'h1, 32'(rail1_in_sequencer));
    // every config code, all fields decoded
    for (i = 0; i < 256; i++)
    begin
      v = i[7:0];
      wr(IDX_RAIL1_CFG, {24'h0, v});
      rd(IDX_RAIL1_CFG, {24'h0, v});
      settle();
      u = 10 * v[EN_UPDLY_LSB +: 2];
      chk("peak_current_limit_select", 32'(v[7:6]), 32'(peak_current_limit_select));
      chk("ade", 32'(v[5]), 32'(active_discharge_enable));
      chk("force", 32'(v[0]), 32'(rail1_force_on));
      chk("up", 32'(u), 32'(rail1_powerup_delay_ms));
      u = v[EN_DNDLY_BIT] ? 30 - u : 0;
      chk("down", 32'(u), 32'(rail1_powerdown_delay_ms));
      chk("seq", 32'(v[EN_SEQ_BIT]), 32'(rail1_in_sequencer));
    end
    // masked flag latches silently, unmask raises, clear drops
    for (i = 0; i < 8; i++)
    begin
      if (i == 6)
        continue;
      wr(IDX_INT_MASK, 32'h1 << i);
      pulse(i);
      chk("irq", 32'h0, 32'(irq));
      rd(IDX_IRQ_STATUS, 32'h1 << i);
      wr(IDX_INT_MASK, 32'h0);
      settle();
      chk("irq", 32'h1, 32'(irq));
      wr(IDX_IRQ_CLEAR, 32'hff);
      settle();
      chk("irq", 32'h0, 32'(irq));
    end
    wr(IDX_IRQ_ENABLE, 32'h0);
    pulse(0);
    chk("irq", 32'h0, 32'(irq));
    wr(IDX_IRQ_ENABLE, 32'hff);
    settle();
    chk("irq", 32'h1, 32'(irq));
    end_sim();
  end
endmodule : simoc_regs_tb_top
